// file: logic/cac_pkg.sv
// Shared constants and carrier types for the aggregation and CPU forward block
package cac_pkg;

  // Widths of the carriers
  localparam int FRONT_W = 16;              // Front port mask width
  localparam int QUEUE_W = 8;               // Extraction queue mask width
  localparam int PORT_W  = 4;               // Ingress port number width
  localparam int ADDR_W  = 10;              // Register byte address width

  // Global register offsets (byte addresses)
  localparam logic [9:0] OFS_FLOW_HASH_CONFIG   = 10'h000;
  localparam logic [9:0] OFS_EXTRACTION_QSEL    = 10'h004;
  localparam logic [9:0] OFS_EXTRACTION_QSEL_2  = 10'h008;
  localparam logic [9:0] OFS_RESERVED_ADDR_QSEL = 10'h00c;
  localparam logic [9:0] OFS_MGMT_VLAN_CFG      = 10'h010;
  localparam logic [9:0] OFS_MGMT_MATCH_VALUE   = 10'h014;
  localparam logic [9:0] OFS_MGMT_MATCH_MASK    = 10'h018;
  localparam logic [9:0] OFS_LAST_RESULT        = 10'h01c;
  // Per-port block: base + port * stride + sub offset
  localparam logic [1:0] PORT_BLK_SEL           = 2'h1;   // addr[9:8]
  localparam logic [1:0] SUB_TYPE_ENABLES       = 2'h0;   // +0x0
  localparam logic [1:0] SUB_BRIDGE_ADDR_CFG    = 2'h1;   // +0x4
  localparam logic [1:0] SUB_ATTRIB_ADDR_CFG    = 2'h2;   // +0x8
  localparam logic [1:0] SUB_CONNCHECK_ADDR_CFG = 2'h3;   // +0xc

  // Field positions of flow_hash_config
  localparam int HASH_DEST_MAC_BIT   = 0;
  localparam int HASH_SRC_MAC_BIT   = 1;
  localparam int HASH_FLOW_BIT   = 2;
  localparam int HASH_IP_BIT     = 3;
  localparam int HASH_L4_BIT     = 4;
  localparam int HASH_RANDOM_BIT = 5;
  // Field positions of cpu_redirect_type_enables
  localparam int TYPE_IGMP_BIT   = 0;
  localparam int TYPE_MLD_BIT    = 1;
  localparam int TYPE_IPMC_BIT   = 2;
  localparam int TYPE_SRCP_BIT   = 3;
  localparam int TYPE_MGMT_BIT   = 4;
  localparam int TYPE_ALLBR_LSB  = 5;       // 2-bit all-bridge action
  // Queue fields, 3 bits each
  localparam int Q_IGMP_LSB = 0;
  localparam int Q_MLD_LSB  = 3;
  localparam int Q_IPMC_LSB = 6;
  localparam int Q_SRCP_LSB = 9;
  localparam int Q_MGMT_LSB = 0;            // In extraction_queue_select_2
  localparam int Q_BR_LSB   = 0;            // In reserved_addr_queue_select
  localparam int Q_ATTR_LSB = 3;
  localparam int Q_CONN_LSB = 6;
  // mgmt_frame_vlan_cfg fields
  localparam int MGMT_VID_LSB   = 0;
  localparam int MGMT_AWARE_BIT = 12;

  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [15:0] RST_LFSR = 16'hace1;

  // Frame constants
  localparam logic [39:0] RSV_MAC_PREFIX = 40'h01_80_c2_00_00;
  localparam logic [7:0]  ALL_BRIDGE_LSB = 8'h10;
  localparam logic [3:0]  RSV_BRIDGE_HI  = 4'h0;
  localparam logic [3:0]  RSV_ATTRIB_HI  = 4'h2;
  localparam logic [3:0]  RSV_CONN_HI    = 4'h3;
  localparam logic [23:0] V4MC_MAC_PREFIX = 24'h01_00_5e;
  localparam logic [15:0] V6MC_MAC_PREFIX = 16'h33_33;
  localparam logic [7:0]  PROTO_IGMP     = 8'h02;
  localparam logic [7:0]  NH_HOP_BY_HOP  = 8'h00;
  localparam logic [7:0]  OPT_ROUTER_ALERT = 8'h05;
  localparam logic [7:0]  OPT_RA_LEN     = 8'h02;
  localparam logic [15:0] OPT_RA_MLD     = 16'h0000;
  localparam logic [23:0] LOCAL_CTRL_NET = 24'he0_00_00;  // 224.0.0.x
  localparam logic [15:0] MGMT_ETHERTYPE = 16'h8880;
  localparam logic [15:0] MGMT_SUB_ID    = 16'h0004;

  // Reserved address actions
  typedef enum logic [1:0] {
    CAC_ACT_NONE     = 2'b00,
    CAC_ACT_COPY     = 2'b01,
    CAC_ACT_REDIRECT = 2'b10,
    CAC_ACT_DISCARD  = 2'b11
  } cac_action_t;

  // Parsed header fields from the frame parser, valid for one cycle
  typedef struct packed {
    logic                valid;
    logic [PORT_W-1:0]   port;
    logic [47:0]         dest_mac;
    logic [47:0]         src_mac;
    logic                is_ipv4;
    logic                is_ipv6;
    logic                is_tcp_udp;
    logic [7:0]          ip_proto;        // IPv4 protocol or IPv6 next hdr
    logic [31:0]         src_ip;
    logic [31:0]         dest_ip;
    logic [19:0]         flow_label;
    logic [15:0]         src_l4_port;
    logic [15:0]         dest_l4_port;
    logic [7:0]          hbh_opt_type;
    logic [7:0]          hbh_opt_len;
    logic [15:0]         hbh_opt_data;
    logic [1:0]          tag_count;
    logic [11:0]         vid;
    logic [15:0]         ethertype;
    logic [15:0]         protocol_sub_identifier;
    logic [31:0]         mgmt_header;
    logic [QUEUE_W-1:0]  other_cpu_qmask; // Requests from other stages
    logic [FRONT_W-1:0]  fwd_mask;        // Normal front port decision
  } cac_hdr_t;

  // Decision to the analyzer
  typedef struct packed {
    logic                valid;
    logic [3:0]          agg_code;
    logic [QUEUE_W-1:0]  cpu_qmask;
    logic                redirect;
    logic                discard;
    logic [FRONT_W-1:0]  fwd_mask;
  } cac_res_t;

endpackage : cac_pkg

// file: logic/cac_classifier.sv
// Aggregation code and CPU forwarding decision of the ingress classifier
`timescale 1ns/1ps

module cac_classifier
  import cac_pkg::*;
#(
  parameter int NUM_PORTS = 11              // Ingress ports served
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  // Parser side
  input  wire cac_hdr_t          hdr_i,
  // Analyzer side
  output cac_res_t               res_o
);

  // Refuse port counts the address map cannot hold
  if (NUM_PORTS < 1 || NUM_PORTS > 16) begin : g_bad_ports
    $error("NUM_PORTS must be 1 to 16");
  end

  // Fold up to 32 bits into one nibble, zero-extended
  function automatic logic [3:0] fold32(input logic [31:0] v);
    logic [3:0] acc;
    acc = 4'h0;
    for (int i = 0; i < 8; i++) begin
      acc = acc ^ v[i*4 +: 4];
    end
    return acc;
  endfunction : fold32

  // One-hot queue bit from a 3-bit queue number
  function automatic logic [QUEUE_W-1:0] qbit(input logic [2:0] q);
    return QUEUE_W'(1) << q;
  endfunction : qbit

  // Two-bit action of one address from a 16-entry table
  function automatic cac_action_t act_of(input logic [31:0] cfg,
                                         input logic [3:0]  idx);
    return cac_action_t'(cfg[{idx, 1'b0} +: 2]);
  endfunction : act_of

  // Global configuration registers
  logic [31:0] flow_hash_config;            // Contribution enables
  logic [31:0] extraction_queue_select;     // Queues per frame type
  logic [31:0] extraction_queue_select_2;   // Management frame queue
  logic [31:0] reserved_addr_queue_select;  // Queues per address class
  logic [31:0] mgmt_frame_vlan_cfg;         // VLAN check settings
  logic [31:0] mgmt_header_match_value;     // Header compare value
  logic [31:0] mgmt_header_match_mask;      // 1 marks don't-care bit
  // Per-port configuration tables
  logic [31:0] cpu_redirect_type_enables      [NUM_PORTS];
  logic [31:0] cpu_redirect_bridge_addr_cfg   [NUM_PORTS];
  logic [31:0] cpu_redirect_attrib_addr_cfg   [NUM_PORTS];
  logic [31:0] cpu_redirect_conncheck_addr_cfg[NUM_PORTS];
  // Block state
  logic [15:0] lfsr;                        // Pseudo-random source
  cac_res_t    res;                         // Output decision register
  logic [31:0] rdata;                       // Read data register

  // Register address decode
  wire        port_blk  = reg_addr_i[9:8] == PORT_BLK_SEL;
  wire [3:0]  port_idx  = reg_addr_i[7:4];
  wire [1:0]  port_sub  = reg_addr_i[3:2];
  // Port slots past NUM_PORTS are not mapped
  wire        port_ok   = port_blk && (32'(port_idx) < NUM_PORTS);
  wire        wr_global = reg_wr_i && !port_blk;
  wire        wr_port   = reg_wr_i && port_ok;

  // Selected ingress port tables, out-of-range ports see zeros
  wire        in_port_ok = 32'(hdr_i.port) < NUM_PORTS;
  wire [31:0] type_en  = in_port_ok ?
                         cpu_redirect_type_enables[hdr_i.port] : RST_ZERO;
  wire [31:0] br_cfg   = in_port_ok ?
                         cpu_redirect_bridge_addr_cfg[hdr_i.port] : RST_ZERO;
  wire [31:0] attr_cfg = in_port_ok ?
                         cpu_redirect_attrib_addr_cfg[hdr_i.port] : RST_ZERO;
  wire [31:0] conn_cfg = in_port_ok ?
                         cpu_redirect_conncheck_addr_cfg[hdr_i.port] :
                         RST_ZERO;

  // Aggregation contributions, each folded to a nibble
  wire [3:0] c_dest_mac = flow_hash_config[HASH_DEST_MAC_BIT] ?
                      fold32({20'h0, hdr_i.dest_mac[11:0]}) : 4'h0;
  wire [3:0] c_src_mac = flow_hash_config[HASH_SRC_MAC_BIT] ?
                      fold32({20'h0, hdr_i.src_mac[11:0]}) : 4'h0;
  wire [3:0] c_flow = (flow_hash_config[HASH_FLOW_BIT] && hdr_i.is_ipv6) ?
                      fold32({12'h0, hdr_i.flow_label}) : 4'h0;
  wire [3:0] c_ip   = (flow_hash_config[HASH_IP_BIT] && hdr_i.is_ipv4) ?
                      fold32({16'h0, hdr_i.src_ip[7:0],
                              hdr_i.dest_ip[7:0]}) : 4'h0;
  // Port numbers count only for IP frames with TCP or UDP
  wire       l4_ok  = (hdr_i.is_ipv4 || hdr_i.is_ipv6) && hdr_i.is_tcp_udp;
  wire [3:0] c_l4   = (flow_hash_config[HASH_L4_BIT] && l4_ok) ?
                      fold32({16'h0, hdr_i.src_l4_port[7:0],
                              hdr_i.dest_l4_port[7:0]}) : 4'h0;
  // Random mode takes the generator instead of the frame
  wire [3:0] frame_code = c_dest_mac ^ c_src_mac ^ c_flow ^ c_ip ^ c_l4;
  wire [3:0] agg_code   = flow_hash_config[HASH_RANDOM_BIT] ?
                          lfsr[3:0] : frame_code;

  // Reserved bridge group address classes
  wire       rsv_pfx  = hdr_i.dest_mac[47:8] == RSV_MAC_PREFIX;
  wire [3:0] rsv_hi   = hdr_i.dest_mac[7:4];
  wire [3:0] rsv_lo   = hdr_i.dest_mac[3:0];
  wire       is_br    = rsv_pfx && rsv_hi == RSV_BRIDGE_HI;
  wire       is_allbr = rsv_pfx && hdr_i.dest_mac[7:0] == ALL_BRIDGE_LSB;
  wire       is_attr  = rsv_pfx && rsv_hi == RSV_ATTRIB_HI;
  wire       is_conn  = rsv_pfx && rsv_hi == RSV_CONN_HI;
  // Action for whichever reserved class matched
  cac_action_t rsv_act;
  always_comb begin
    // Default is no action
    rsv_act = CAC_ACT_NONE;
    if (is_br) begin
      rsv_act = act_of(br_cfg, rsv_lo);
    end else if (is_allbr) begin
      rsv_act = cac_action_t'(type_en[TYPE_ALLBR_LSB +: 2]);
    end else if (is_attr) begin
      rsv_act = act_of(attr_cfg, rsv_lo);
    end else if (is_conn) begin
      rsv_act = act_of(conn_cfg, rsv_lo);
    end
  end
  // Reserved address queue by class
  wire [2:0] rsv_q = (is_br || is_allbr) ?
                     reserved_addr_queue_select[Q_BR_LSB +: 3] :
                     is_attr ? reserved_addr_queue_select[Q_ATTR_LSB +: 3] :
                     reserved_addr_queue_select[Q_CONN_LSB +: 3];
  // Decoded action of the matched class
  wire rsv_redir = rsv_act == CAC_ACT_REDIRECT;
  wire rsv_copy  = rsv_act == CAC_ACT_COPY;
  wire rsv_disc  = rsv_act == CAC_ACT_DISCARD;

  // Multicast control frame detection
  wire v4mc_mac = hdr_i.dest_mac[47:24] == V4MC_MAC_PREFIX &&
                  !hdr_i.dest_mac[23];
  wire is_igmp  = v4mc_mac && hdr_i.is_ipv4 &&
                  hdr_i.ip_proto == PROTO_IGMP;
  // Port enables gate each frame type
  wire igmp_hit = type_en[TYPE_IGMP_BIT] && is_igmp;
  // Router alert must be the first hop-by-hop option
  wire mld_hit  = type_en[TYPE_MLD_BIT] &&
                  hdr_i.dest_mac[47:32] == V6MC_MAC_PREFIX &&
                  hdr_i.is_ipv6 && hdr_i.ip_proto == NH_HOP_BY_HOP &&
                  hdr_i.hbh_opt_type == OPT_ROUTER_ALERT &&
                  hdr_i.hbh_opt_len == OPT_RA_LEN &&
                  hdr_i.hbh_opt_data == OPT_RA_MLD;
  // IGMP frames are left to the redirect path
  wire ipmc_hit = type_en[TYPE_IPMC_BIT] && v4mc_mac && hdr_i.is_ipv4 &&
                  !is_igmp &&
                  hdr_i.dest_ip[31:8] == LOCAL_CTRL_NET;
  // Every frame of a copying port
  wire srcp_hit = type_en[TYPE_SRCP_BIT];

  // Management frame filter, three checks
  wire mgmt_aware = mgmt_frame_vlan_cfg[MGMT_AWARE_BIT];
  wire [11:0] mgmt_vid = mgmt_frame_vlan_cfg[MGMT_VID_LSB +: 12];
  wire vlan_ok   = mgmt_aware ?
                   (hdr_i.tag_count == 2'd1 && hdr_i.vid == mgmt_vid) :
                   (hdr_i.tag_count == 2'd0);
  wire etype_ok  = hdr_i.ethertype == MGMT_ETHERTYPE &&
                   hdr_i.protocol_sub_identifier == MGMT_SUB_ID;
  // Mask bit set makes that header bit a don't-care
  wire hdr_ok    = ((hdr_i.mgmt_header ^ mgmt_header_match_value) &
                    ~mgmt_header_match_mask) == RST_ZERO;
  wire mgmt_hit  = type_en[TYPE_MGMT_BIT] &&
                   vlan_ok && etype_ok && hdr_ok;

  // Queue mask built from every event of this stage except discard
  wire [QUEUE_W-1:0] own_qmask =
    (igmp_hit ? qbit(extraction_queue_select[Q_IGMP_LSB +: 3]) : '0) |
    (mld_hit  ? qbit(extraction_queue_select[Q_MLD_LSB +: 3])  : '0) |
    (ipmc_hit ? qbit(extraction_queue_select[Q_IPMC_LSB +: 3]) : '0) |
    (srcp_hit ? qbit(extraction_queue_select[Q_SRCP_LSB +: 3]) : '0) |
    (mgmt_hit ? qbit(extraction_queue_select_2[Q_MGMT_LSB +: 3]) : '0) |
    ((rsv_redir || rsv_copy) ? qbit(rsv_q) : '0);
  wire [QUEUE_W-1:0] next_qmask = own_qmask | hdr_i.other_cpu_qmask;
  // Redirect or discard removes front ports, copy keeps them
  wire redirect  = igmp_hit || mld_hit || mgmt_hit || rsv_redir;
  // Discard adds no queue, it only removes front ports
  wire clear_fwd = redirect || rsv_disc;
  wire [FRONT_W-1:0] next_fwd = clear_fwd ? '0 : hdr_i.fwd_mask;

  // Read data selection
  logic [31:0] rd_sel;
  always_comb begin
    // Unmapped addresses read zero
    rd_sel = RST_ZERO;
    if (port_blk) begin
      if (port_ok) begin
        unique case (port_sub)
          SUB_TYPE_ENABLES:       rd_sel =
            cpu_redirect_type_enables[port_idx];
          SUB_BRIDGE_ADDR_CFG:    rd_sel =
            cpu_redirect_bridge_addr_cfg[port_idx];
          SUB_ATTRIB_ADDR_CFG:    rd_sel =
            cpu_redirect_attrib_addr_cfg[port_idx];
          SUB_CONNCHECK_ADDR_CFG: rd_sel =
            cpu_redirect_conncheck_addr_cfg[port_idx];
        endcase
      end
    end else begin
      case (reg_addr_i)
        OFS_FLOW_HASH_CONFIG:   rd_sel = flow_hash_config;
        OFS_EXTRACTION_QSEL:    rd_sel = extraction_queue_select;
        OFS_EXTRACTION_QSEL_2:  rd_sel = extraction_queue_select_2;
        OFS_RESERVED_ADDR_QSEL: rd_sel = reserved_addr_queue_select;
        OFS_MGMT_VLAN_CFG:      rd_sel = mgmt_frame_vlan_cfg;
        OFS_MGMT_MATCH_VALUE:   rd_sel = mgmt_header_match_value;
        OFS_MGMT_MATCH_MASK:    rd_sel = mgmt_header_match_mask;
        OFS_LAST_RESULT:        rd_sel = {14'h0, res.discard, res.redirect,
                                          res.cpu_qmask, 4'h0, res.agg_code};
        default:                rd_sel = RST_ZERO;
      endcase
    end
  end

  // Global register writes, only implemented bits kept
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flow_hash_config           <= RST_ZERO;
      extraction_queue_select    <= RST_ZERO;
      extraction_queue_select_2  <= RST_ZERO;
      reserved_addr_queue_select <= RST_ZERO;
      mgmt_frame_vlan_cfg        <= RST_ZERO;
      mgmt_header_match_value    <= RST_ZERO;
      mgmt_header_match_mask     <= RST_ZERO;
    end else if (wr_global) begin
      // Unimplemented bits are dropped and read zero
      case (reg_addr_i)
        OFS_FLOW_HASH_CONFIG:   flow_hash_config <= {26'h0, reg_wdata_i[5:0]};
        OFS_EXTRACTION_QSEL:    extraction_queue_select <=
                                  {20'h0, reg_wdata_i[11:0]};
        OFS_EXTRACTION_QSEL_2:  extraction_queue_select_2 <=
                                  {29'h0, reg_wdata_i[2:0]};
        OFS_RESERVED_ADDR_QSEL: reserved_addr_queue_select <=
                                  {23'h0, reg_wdata_i[8:0]};
        OFS_MGMT_VLAN_CFG:      mgmt_frame_vlan_cfg <=
                                  {19'h0, reg_wdata_i[12:0]};
        OFS_MGMT_MATCH_VALUE:   mgmt_header_match_value <= reg_wdata_i;
        OFS_MGMT_MATCH_MASK:    mgmt_header_match_mask <= reg_wdata_i;
        default:                ;
      endcase
    end
  end

  // Per-port register writes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        cpu_redirect_type_enables[p]       <= RST_ZERO;
        cpu_redirect_bridge_addr_cfg[p]    <= RST_ZERO;
        cpu_redirect_attrib_addr_cfg[p]    <= RST_ZERO;
        cpu_redirect_conncheck_addr_cfg[p] <= RST_ZERO;
      end
    end else if (wr_port) begin
      unique case (port_sub)
        SUB_TYPE_ENABLES:       cpu_redirect_type_enables[port_idx] <=
                                  {25'h0, reg_wdata_i[6:0]};
        SUB_BRIDGE_ADDR_CFG:    cpu_redirect_bridge_addr_cfg[port_idx] <=
                                  reg_wdata_i;
        SUB_ATTRIB_ADDR_CFG:    cpu_redirect_attrib_addr_cfg[port_idx] <=
                                  reg_wdata_i;
        SUB_CONNCHECK_ADDR_CFG: cpu_redirect_conncheck_addr_cfg[port_idx] <=
                                  reg_wdata_i;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata <= RST_ZERO;
    end else begin
      // Zero outside the answer cycle keeps the bus quiet
      rdata <= reg_rd_i ? rd_sel : RST_ZERO;
    end
  end

  // Free-running generator, x^16+x^14+x^13+x^11
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lfsr <= RST_LFSR;
    end else begin
      // Steps in every mode, so a late enable starts mid-sequence
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  // Decision register, valid one cycle after the header
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      res <= '0;
    end else begin
      // Pulse follows the header by one cycle
      res.valid <= hdr_i.valid;
      // Data fields hold until the next frame
      if (hdr_i.valid) begin
        res.agg_code  <= agg_code;
        res.cpu_qmask <= next_qmask;
        res.redirect  <= redirect;
        res.discard   <= rsv_disc;
        res.fwd_mask  <= next_fwd;
      end
    end
  end

  // Outputs straight from registers
  assign reg_rdata_o = rdata;
  assign res_o       = res;

endmodule : cac_classifier

// file: testbench/cac_classifier_properties.sv
// Port assertions for the classifier
`timescale 1ns/1ps
module cac_classifier_properties
  import cac_pkg::*;
(
  // Clock, reset, register port
  input wire logic              clk_i,
  input wire logic              rst_b_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0]       reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [31:0]       reg_rdata_o,
  // Frame path
  input wire cac_hdr_t          hdr_i,
  input wire cac_res_t          res_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  res_pulse_a:
    assert property (hdr_i.valid |=> res_o.valid) else $error("no result");
  no_spur_a:
    assert property (!hdr_i.valid |=> !res_o.valid) else $error("spurious");
  redir_clear_a:
    assert property (res_o.valid && (res_o.redirect || res_o.discard)
      |-> res_o.fwd_mask == '0) else $error("front ports kept");
  copy_keep_a:
    assert property (hdr_i.valid |=> res_o.redirect || res_o.discard ||
      res_o.fwd_mask == $past(hdr_i.fwd_mask)) else $error("fwd changed");
  qmask_or_a:
    assert property (hdr_i.valid |=> (res_o.cpu_qmask |
      $past(hdr_i.other_cpu_qmask)) == res_o.cpu_qmask)
      else $error("other queues lost");
  plain_pass_a:
    assert property (hdr_i.valid && !hdr_i.dest_mac[40] &&
      hdr_i.ethertype != MGMT_ETHERTYPE |=> !res_o.redirect && !res_o.discard)
      else $error("unicast frame redirected");
  result_hold_a:
    assert property (!hdr_i.valid |=> $stable(res_o.agg_code) &&
      $stable(res_o.cpu_qmask)) else $error("result moved");
  rdata_idle_a:
    assert property (!reg_rd_i |=> reg_rdata_o == '0) else $error("rdata");
  unmapped_rd_a:
    assert property (reg_rd_i && reg_addr_i[9:8] == 2'h3 |=>
      reg_rdata_o == '0) else $error("unmapped read");
endmodule : cac_classifier_properties
bind cac_classifier cac_classifier_properties cac_classifier_properties_i (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .hdr_i(hdr_i), .res_o(res_o));

// file: testbench/cac_parser_model.sv
// Frame parser model, one header per send
`timescale 1ns/1ps
module cac_parser_model
  import cac_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Header to the classifier
  output cac_hdr_t hdr_o
);
  initial hdr_o = '0;
  // One cycle of valid, then scrambled released fields
  task automatic send(input cac_hdr_t h);
    cac_hdr_t r;
    r = ~h;
    r.valid = 1'b0;
    h.valid = 1'b1;
    @(posedge clk_i);
    hdr_o <= h;
    @(posedge clk_i);
    hdr_o <= r;
  endtask : send
endmodule : cac_parser_model

// file: testbench/tb.sv
// Self-checking bench for the classifier
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  bad_count++; $display("Error %s exp %h got %h", nm, e, g); end end
module tb
  import cac_pkg::*;
;
  logic              clk_i = 1'b0;
  logic              rst_b_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [31:0]       reg_wdata_i = '0;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic [31:0]       reg_rdata_o;
  cac_hdr_t          hdr_i;
  cac_res_t          res_o;
  logic [31:0]       rd_q[$];
  cac_res_t          res_q[$];
  logic [31:0]       exp_rd;
  cac_res_t          exp_res;
  logic              rd_seen = 1'b0;
  int                bad_count = 0;
  int                comparisons = 0;
  int                cycles = 0;
  logic [31:0]       d;
  logic [5:0]        cfg;
  logic [3:0]        ag;
  cac_hdr_t          h;
  logic [$bits(cac_hdr_t)-1:0] hv;
  logic [15:0]       lf, lf_d;
  logic              rnd = 1'b0;
  localparam logic [9:0] ADR [10] = '{10'h000, 10'h004, 10'h008, 10'h00c,
    10'h010, 10'h014, 10'h018, 10'h100, 10'h104, 10'h3fc};
  localparam logic [31:0] MSK [10] = '{32'h3f, 32'hfff, 32'h7, 32'h1ff,
    32'h1fff, '1, '1, 32'h7f, '1, 32'h0};
  cac_classifier #(.NUM_PORTS(11)) cac_classifier_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .hdr_i(hdr_i), .res_o(res_o));
  cac_parser_model cac_parser_model_i (.clk_i(clk_i), .hdr_o(hdr_i));
  initial forever #5 clk_i = ~clk_i;
  // Monitor: compare outputs with the oldest note
  always @(posedge clk_i) begin
    rd_seen <= reg_rd_i;
    // Generator model, reloaded while reset is held
    lf <= !rst_b_i ? RST_LFSR :
          {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    lf_d <= lf;
    cycles++;
    if (rd_seen) begin
      exp_rd = rd_q.pop_front();
      `CHK("rdata", exp_rd, reg_rdata_o)
    end
    if (res_o.valid === 1'b1) begin
      exp_res = res_q.pop_front();
      if (rnd) exp_res.agg_code = lf_d[3:0];
      `CHK("result", exp_res, res_o)
    end
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
  endtask : rd
  task automatic send(input cac_hdr_t f, input logic [3:0] a,
                      input logic [7:0] q, input logic r, input logic x);
    res_q.push_back({1'b1, a, q | f.other_cpu_qmask, r, x,
                     (r | x) ? 16'h0 : f.fwd_mask});
    cac_parser_model_i.send(f);
  endtask : send
  function automatic logic [3:0] fold(input logic [19:0] v);
    return v[3:0] ^ v[7:4] ^ v[11:8] ^ v[15:12] ^ v[19:16];
  endfunction : fold
  function automatic cac_hdr_t base(input logic [3:0] p, input logic [47:0] m);
    cac_hdr_t b;
    b = '0;
    b.port = p;
    b.dest_mac = m;
    b.ethertype = 16'h0800;
    b.other_cpu_qmask = 8'($urandom);
    b.fwd_mask = 16'($urandom);
    return b;
  endfunction : base
  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    d = $urandom(44);
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    // Reset value, masked write back, unmapped place
    for (int i = 0; i < 10; i++) begin
      rd(ADR[i], 32'h0);
      d = $urandom;
      wr(ADR[i], d);
      rd(ADR[i], d & MSK[i]);
      wr(ADR[i], 32'h0);
    end
    // Random fields, random contribution choice
    for (int i = 0; i < 40; i++) begin
      cfg = 6'($urandom) & 6'h1f;
      wr(OFS_FLOW_HASH_CONFIG, {26'h0, cfg});
      for (int k = 0; k < 12; k++) hv = (hv << 32) | $bits(hv)'($urandom);
      h = hv;
      h.port = 4'h0;
      h.dest_mac[40] = 1'b0;
      h.ethertype = 16'h0800;
      h.is_ipv6 = h.is_ipv6 & ~h.is_ipv4;
      ag = 4'h0;
      if (cfg[0]) ag ^= fold({8'h0, h.dest_mac[11:0]});
      if (cfg[1]) ag ^= fold({8'h0, h.src_mac[11:0]});
      if (cfg[2] && h.is_ipv6) ag ^= fold(h.flow_label);
      if (cfg[3] && h.is_ipv4)
        ag ^= fold({4'h0, h.src_ip[7:0], h.dest_ip[7:0]});
      if (cfg[4] && (h.is_ipv4 || h.is_ipv6) && h.is_tcp_udp)
        ag ^= fold({4'h0, h.src_l4_port[7:0], h.dest_l4_port[7:0]});
      send(h, ag, 8'h0, 1'b0, 1'b0);
    end
    // Random mode: code from the generator, frame ignored
    wr(OFS_FLOW_HASH_CONFIG, 32'h3f);
    rnd = 1'b1;
    repeat (4) send(h, 4'h0, 8'h0, 1'b0, 1'b0);
    // Queues and per-port actions
    wr(OFS_FLOW_HASH_CONFIG, 32'h0);
    rnd = 1'b0;
    wr(OFS_EXTRACTION_QSEL, 32'h8d1);
    wr(OFS_EXTRACTION_QSEL_2, 32'h5);
    wr(OFS_RESERVED_ADDR_QSEL, 32'h3e);
    wr(OFS_MGMT_MATCH_VALUE, 32'h1234_5678);
    wr(OFS_MGMT_MATCH_MASK, 32'hff);
    wr(10'h110, 32'h3f);
    wr(10'h114, 32'h800);
    wr(10'h118, 32'h4);
    wr(10'h12c, 32'hc000_0000);
    h = base(4'h1, 48'h0100_5e0a_0b0c);
    h.is_ipv4 = 1'b1;
    h.ip_proto = PROTO_IGMP;
    send(h, 4'h0, 8'h12, 1'b1, 1'b0);
    h.ip_proto = 8'h11;
    h.dest_ip = 32'he000_0005;
    send(h, 4'h0, 8'h18, 1'b0, 1'b0);
    h = base(4'h1, 48'h3333_0000_0001);
    h.is_ipv6 = 1'b1;
    h.hbh_opt_type = OPT_ROUTER_ALERT;
    h.hbh_opt_len = OPT_RA_LEN;
    send(h, 4'h0, 8'h14, 1'b1, 1'b0);
    h = base(4'h1, 48'h0200_0000_0001);
    h.ethertype = MGMT_ETHERTYPE;
    h.protocol_sub_identifier = MGMT_SUB_ID;
    h.mgmt_header = 32'h1234_56aa;
    send(h, 4'h0, 8'h30, 1'b1, 1'b0);
    h.tag_count = 2'h1;
    send(h, 4'h0, 8'h10, 1'b0, 1'b0);
    h.tag_count = 2'h0;
    h.mgmt_header = 32'h1334_56aa;
    send(h, 4'h0, 8'h10, 1'b0, 1'b0);
    // VLAN-aware filter: one tag with the set VID only
    wr(OFS_MGMT_VLAN_CFG, 32'h1abc);
    h.mgmt_header = 32'h1234_56aa;
    h.tag_count = 2'h1;
    h.vid = 12'habc;
    send(h, 4'h0, 8'h30, 1'b1, 1'b0);
    h.vid = 12'habd;
    send(h, 4'h0, 8'h10, 1'b0, 1'b0);
    h.vid = 12'habc;
    h.tag_count = 2'h2;
    send(h, 4'h0, 8'h10, 1'b0, 1'b0);
    h.tag_count = 2'h0;
    send(h, 4'h0, 8'h10, 1'b0, 1'b0);
    h = base(4'h1, 48'h0180_c200_0005);
    send(h, 4'h0, 8'h50, 1'b1, 1'b0);
    h.dest_mac[7:0] = ALL_BRIDGE_LSB;
    send(h, 4'h0, 8'h50, 1'b0, 1'b0);
    h.dest_mac[7:0] = 8'h21;
    send(h, 4'h0, 8'h90, 1'b0, 1'b0);
    h.port = 4'h2;
    h.dest_mac[7:0] = 8'h3f;
    send(h, 4'h0, 8'h00, 1'b0, 1'b1);
    rd(OFS_LAST_RESULT, {14'h0, 2'h2, h.other_cpu_qmask, 8'h0});
    repeat (3) @(posedge clk_i);
    report_and_stop();
  end
endmodule : tb
